/* File: line_interface_control_regs.v */
`timescale 1ns/1ns
`include "line_ctrl_map.vh"
module line_interface_control_regs (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire hardware_reset_n,
  input wire hardware_mode,
  // register port
  input wire wr_en,
  input wire rd_en,
  input wire [4:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  // mode and code definition
  input wire e1_t1_select,
  input wire [7:0] tx_code_def_one,
  input wire [7:0] tx_code_def_two,
  // line side pins
  input wire tx_clock_in,
  input wire jitter_atten_clock,
  input wire tx_positive_data,
  input wire tx_negative_data,
  input wire rx_line_data,
  input wire rx_all_ones,
  output reg line_out_a,
  output reg line_out_b,
  output reg line_out_oe,
  output reg line_open_drain,
  output reg status_pin,
  output reg rx_carrier_loss,
  // control outputs to datapath
  output reg rx_zero_subst_disable,
  output reg tx_zero_subst_disable,
  output reg rx_update_edge_select,
  output reg [2:0] buildout_code,
  output reg [1:0] rx_sensitivity,
  output reg jitter_atten_side,
  output reg jitter_atten_disable,
  output reg [7:0] jitter_depth_bits,
  output reg line_reset_active
);
  // ==========================================================
  // widths cut from the shared constants
  localparam [31:0] STALL_FULL = `TX_CLOCK_STALL_CYC;
  localparam [31:0] LRST_FULL = `LINE_RESET_CYC;
  localparam [31:0] LOSS_E1_FULL = `CARRIER_LOSS_ZEROS_E1;
  localparam [31:0] LOSS_T1_FULL = `CARRIER_LOSS_ZEROS_T1;
  localparam [5:0] STALL_LIMIT = STALL_FULL[5:0];
  localparam [2:0] LRST_LEN = LRST_FULL[2:0];
  localparam [7:0] LOSS_E1 = LOSS_E1_FULL[7:0];
  localparam [7:0] LOSS_T1 = LOSS_T1_FULL[7:0];
  // one-hot states of the line reset sequencer
  localparam [1:0] LR_IDLE = 2'h1;
  localparam [1:0] LR_BUSY = 2'h2;
  // ==========================================================
  // input synchronisers
  reg [1:0] s_hardware_reset_n;
  reg [1:0] s_tx_clock_in;
  reg [1:0] s_jclk;
  reg [1:0] s_tx_positive_data;
  reg [1:0] s_tx_negative_data;
  reg [1:0] s_rxd;
  reg [1:0] s_rao;
  reg [1:0] s_hwm;
  reg tx_clock_in_d;
  reg jclk_d;
  always @(posedge clk) begin
    if (rst) begin
      s_hardware_reset_n <= 2'h3;
      s_tx_clock_in <= 2'h0;
      s_jclk <= 2'h0;
      s_tx_positive_data <= 2'h0;
      s_tx_negative_data <= 2'h0;
      s_rxd <= 2'h0;
      s_rao <= 2'h0;
      s_hwm <= 2'h0;
      tx_clock_in_d <= 1'b0;
      jclk_d <= 1'b0;
    end else begin
      s_hardware_reset_n <= {s_hardware_reset_n[0], hardware_reset_n};
      s_tx_clock_in <= {s_tx_clock_in[0], tx_clock_in};
      s_jclk <= {s_jclk[0], jitter_atten_clock};
      s_tx_positive_data <= {s_tx_positive_data[0], tx_positive_data};
      s_tx_negative_data <= {s_tx_negative_data[0], tx_negative_data};
      s_rxd <= {s_rxd[0], rx_line_data};
      s_rao <= {s_rao[0], rx_all_ones};
      s_hwm <= {s_hwm[0], hardware_mode};
      tx_clock_in_d <= s_tx_clock_in[1];
      jclk_d <= s_jclk[1];
    end
  end
  // level sensitive: any cycle with the pin low holds defaults
  wire soft_rst = rst | ~s_hardware_reset_n[1];
  wire tx_clock_in_rise = s_tx_clock_in[1] & ~tx_clock_in_d;
  wire tx_clock_in_fall = ~s_tx_clock_in[1] & tx_clock_in_d;
  wire jclk_rise = s_jclk[1] & ~jclk_d;
  // ==========================================================
  // control registers
  reg [7:0] ctrl_two;
  reg [7:0] ctrl_three;
  reg [7:0] ctrl_four;
  always @(posedge clk) begin
    if (soft_rst) begin
      ctrl_two <= `RST_CTRL;
      ctrl_three <= `RST_CTRL;
      ctrl_four <= `RST_CTRL;
    end else if (wr_en) begin
      if (addr == `OFS_CTRL_TWO) ctrl_two <= wr_data;
      if (addr == `OFS_CTRL_THREE) ctrl_three <= wr_data;
      if (addr == `OFS_CTRL_FOUR) ctrl_four <= wr_data;
    end
  end
  always @(posedge clk) begin
    if (soft_rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `OFS_CTRL_TWO: rd_data <= ctrl_two;
        `OFS_CTRL_THREE: rd_data <= ctrl_three;
        `OFS_CTRL_FOUR: rd_data <= ctrl_four;
        default: rd_data <= 8'h00;
      endcase
    end
  end
  // hardware mode holds the selector at zero
  wire pin_select = ctrl_two[`B_STATUS_PIN_SELECT] & ~s_hwm[1];
  wire custom_drv = ctrl_two[`B_CUSTOM_DRIVER_SELECT];
  wire tx_edge = ctrl_two[`B_TX_SAMPLE_EDGE_SELECT];
  wire tx_enable = ctrl_three[`B_TX_DATA_ENABLE];
  wire [2:0] bo_code = ctrl_four[`B_BUILDOUT_MSB:`B_BUILDOUT_LSB];
  // ==========================================================
  // zero-to-one detectors
  wire lrst_p;
  wire bpv_p;
  wire err_p;
  rise_detect u_lrst (.clk(clk), .rst(soft_rst),
    .level(ctrl_three[`B_LINE_RESET]), .pulse(lrst_p));
  rise_detect u_bpv (.clk(clk), .rst(soft_rst),
    .level(ctrl_three[`B_VIOLATION_INSERT]), .pulse(bpv_p));
  rise_detect u_err (.clk(clk), .rst(soft_rst),
    .level(ctrl_three[`B_BIT_ERROR_INSERT]), .pulse(err_p));
  // ==========================================================
  // carrier loss and tx clock watchdog
  reg [7:0] zero_cnt;
  reg [5:0] stall_cnt;
  reg tx_clock_in_stalled;
  wire [7:0] loss_limit = e1_t1_select ? LOSS_T1 : LOSS_E1;
  // stop one short, so loss rises on the limit-th zero itself
  wire [7:0] loss_last = loss_limit - 8'h01;
  always @(posedge clk) begin
    if (soft_rst) begin
      zero_cnt <= 8'h00;
      rx_carrier_loss <= 1'b0;
      stall_cnt <= 6'h00;
      tx_clock_in_stalled <= 1'b0;
    end else begin
      // rx data counted once per rx bit, on tx clock timing as a proxy
      if (tx_clock_in_rise) begin
        if (s_rxd[1]) begin
          zero_cnt <= 8'h00;
          rx_carrier_loss <= 1'b0;
        end else if (zero_cnt < loss_last) begin
          zero_cnt <= zero_cnt + 8'h01;
        end else begin
          rx_carrier_loss <= 1'b1;
        end
      end
      if (tx_clock_in_rise | tx_clock_in_fall) begin
        stall_cnt <= 6'h00;
        tx_clock_in_stalled <= 1'b0;
      end else if (stall_cnt < STALL_LIMIT) begin
        stall_cnt <= stall_cnt + 6'h01;
      end else begin
        tx_clock_in_stalled <= 1'b1;
      end
    end
  end
  // ==========================================================
  // line reset sequencer
  // a fresh rise restarts the window, so a quick re-toggle never shortens it
  reg [1:0] lr_state;
  reg [1:0] next_lr_state;
  reg [2:0] lrst_cnt;
  reg [2:0] next_lrst_cnt;
  always @* begin
    next_lr_state = lr_state;
    next_lrst_cnt = lrst_cnt;
    case (lr_state)
      LR_IDLE: begin
        if (lrst_p) begin
          next_lr_state = LR_BUSY;
          next_lrst_cnt = LRST_LEN - 3'h1;
        end
      end
      LR_BUSY: begin
        if (lrst_p) begin
          next_lrst_cnt = LRST_LEN - 3'h1;
        end else if (lrst_cnt == 3'h0) begin
          next_lr_state = LR_IDLE;
        end else begin
          next_lrst_cnt = lrst_cnt - 3'h1;
        end
      end
      default: begin
        next_lr_state = LR_IDLE;
        next_lrst_cnt = 3'h0;
      end
    endcase
  end
  always @(posedge clk) begin
    if (soft_rst) begin
      lr_state <= LR_IDLE;
      lrst_cnt <= 3'h0;
    end else begin
      lr_state <= next_lr_state;
      lrst_cnt <= next_lrst_cnt;
    end
  end
  // ==========================================================
  // transmit pattern generation
  reg [19:0] prbs;
  reg alt_bit;
  reg sq_bit;
  reg [3:0] code_idx;
  reg [1:0] ones_run;
  reg bpv_armed;
  reg err_armed;
  reg last_mark_b;
  reg mark_d;
  reg data_d;
  wire prbs_fb = e1_t1_select ? (prbs[19] ^ prbs[16]) : (prbs[14] ^ prbs[13]);
  wire [15:0] code_word = {tx_code_def_one, tx_code_def_two};
  wire tx_sample = tx_edge ? tx_clock_in_rise : tx_clock_in_fall;
  wire all_ones = ~tx_enable |
    (ctrl_three[`B_AUTO_ALL_ONES] & (rx_carrier_loss | s_rao[1]));
  // all-ones runs on jitter clock; other patterns on tx clock
  wire bit_tick = all_ones ? jclk_rise : tx_sample;
  reg raw_bit;
  always @* begin
    raw_bit = s_tx_positive_data[1] | s_tx_negative_data[1];
    if (all_ones) raw_bit = 1'b1;
    else if (ctrl_three[`B_TX_ALTERNATING]) raw_bit = alt_bit;
    else if (ctrl_three[`B_TX_PRBS]) raw_bit = prbs[0];
    else if (ctrl_three[`B_TX_LOOP_CODE]) raw_bit = code_word[code_idx];
  end
  always @(posedge clk) begin
    if (soft_rst) begin
      prbs <= 20'hFFFFF;
      alt_bit <= 1'b1;
      sq_bit <= 1'b0;
      code_idx <= 4'hF;
      ones_run <= 2'h0;
      bpv_armed <= 1'b0;
      err_armed <= 1'b0;
      last_mark_b <= 1'b0;
      mark_d <= 1'b0;
      data_d <= 1'b0;
    end else begin
      if (bpv_p) bpv_armed <= 1'b1;
      if (err_p) err_armed <= 1'b1;
      if (bit_tick) begin
        prbs <= {prbs[18:0], prbs_fb};
        alt_bit <= ~alt_bit;
        sq_bit <= ~sq_bit;
        code_idx <= code_idx - 4'h1;
        data_d <= raw_bit ^ err_armed;
        if (err_armed & ~err_p) err_armed <= 1'b0;
        if (raw_bit) begin
          ones_run <= (ones_run == 2'h3) ? 2'h3 : ones_run + 2'h1;
          if (bpv_armed & ones_run == 2'h2) begin
            // violation keeps last_mark_b, so the next mark repeats the violation polarity
            mark_d <= 1'b1;
            if (~bpv_p) bpv_armed <= 1'b0;
          end else begin
            last_mark_b <= ~last_mark_b;
            mark_d <= 1'b0;
          end
        end else begin
          ones_run <= 2'h0;
        end
      end
    end
  end
  // ==========================================================
  // line driver
  always @(posedge clk) begin
    if (soft_rst) begin
      line_out_a <= 1'b0;
      line_out_b <= 1'b0;
      line_out_oe <= 1'b0;
      line_open_drain <= 1'b0;
      status_pin <= 1'b0;
      rx_zero_subst_disable <= 1'b0;
      tx_zero_subst_disable <= 1'b0;
      rx_update_edge_select <= 1'b0;
      buildout_code <= 3'h0;
      rx_sensitivity <= 2'h0;
      jitter_atten_side <= 1'b0;
      jitter_atten_disable <= 1'b0;
      jitter_depth_bits <= `DEPTH_DEEP;
      line_reset_active <= 1'b0;
    end else begin
      line_out_oe <= ~ctrl_four[`B_TX_POWER_DOWN];
      if (custom_drv & bo_code == 3'h0) begin
        line_out_a <= sq_bit;
        line_out_b <= ~sq_bit;
      end else begin
        line_out_a <= data_d & (mark_d ? ~last_mark_b : last_mark_b);
        line_out_b <= data_d & (mark_d ? last_mark_b : ~last_mark_b);
      end
      line_open_drain <= custom_drv & (bo_code != 3'h0);
      status_pin <= pin_select ? tx_clock_in_stalled : rx_carrier_loss;
      rx_zero_subst_disable <= ctrl_two[`B_RX_ZERO_SUBST_DISABLE];
      tx_zero_subst_disable <= ctrl_two[`B_TX_ZERO_SUBST_DISABLE];
      rx_update_edge_select <= ctrl_two[`B_RX_UPDATE_EDGE_SELECT];
      buildout_code <= bo_code;
      rx_sensitivity <= {e1_t1_select, ctrl_four[`B_EQUALIZER_GAIN]};
      jitter_atten_side <= ctrl_four[`B_JITTER_SIDE];
      jitter_atten_disable <= ctrl_four[`B_JITTER_DISABLE];
      jitter_depth_bits <= ctrl_four[`B_JITTER_DEPTH] ? `DEPTH_SHALLOW : `DEPTH_DEEP;
      line_reset_active <= (lr_state == LR_BUSY);
    end
  end
endmodule

/* File: line_ctrl_map.vh */
`ifndef LINE_CTRL_MAP_VH
`define LINE_CTRL_MAP_VH
// ==========================================================
// register offsets
`define OFS_CTRL_TWO 5'h01
`define OFS_CTRL_THREE 5'h02
`define OFS_CTRL_FOUR 5'h03
// ==========================================================
// reset values
`define RST_CTRL 8'h00
// ==========================================================
// control two fields
`define B_STATUS_PIN_SELECT 7
`define B_CUSTOM_DRIVER_SELECT 4
`define B_RX_ZERO_SUBST_DISABLE 3
`define B_TX_ZERO_SUBST_DISABLE 2
`define B_TX_SAMPLE_EDGE_SELECT 1
`define B_RX_UPDATE_EDGE_SELECT 0
// ==========================================================
// control three fields
`define B_TX_DATA_ENABLE 7
`define B_AUTO_ALL_ONES 6
`define B_TX_ALTERNATING 5
`define B_TX_PRBS 4
`define B_TX_LOOP_CODE 3
`define B_LINE_RESET 2
`define B_VIOLATION_INSERT 1
`define B_BIT_ERROR_INSERT 0
// ==========================================================
// control four fields
`define B_BUILDOUT_MSB 7
`define B_BUILDOUT_LSB 5
`define B_EQUALIZER_GAIN 4
`define B_JITTER_SIDE 3
`define B_JITTER_DEPTH 2
`define B_JITTER_DISABLE 1
`define B_TX_POWER_DOWN 0
// ==========================================================
// timing and counts
`define CLK_PERIOD_NS 100
`define TX_CLOCK_STALL_NS 5000
`define TX_CLOCK_STALL_CYC ((`TX_CLOCK_STALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CARRIER_LOSS_ZEROS_E1 255
`define CARRIER_LOSS_ZEROS_T1 192
`define DEPTH_DEEP 8'h80
`define DEPTH_SHALLOW 8'h20
`define LINE_RESET_CYC 4
`endif

/* File: rise_detect.v */
`timescale 1ns/1ns
// ==========================================================
// rise detector against last stored control value
module rise_detect (
  input wire clk,
  input wire rst,
  input wire level,
  output reg pulse
);
  reg last;
  always @(posedge clk) begin
    if (rst) begin
      last <= 1'b0;
      pulse <= 1'b0;
    end else begin
      last <= level;
      pulse <= level & ~last;
    end
  end
endmodule

/* File: line_ctrl_checks_properties.sv */
`timescale 1ns/1ns
// ==========================================================
// port-level checks of the control registers
module line_ctrl_checks (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire hardware_reset_n,
  // register port
  input wire wr_en,
  input wire [4:0] addr,
  input wire [7:0] wr_data,
  // observed outputs
  input wire e1_t1_select,
  input wire line_out_oe,
  input wire rx_zero_subst_disable,
  input wire tx_zero_subst_disable,
  input wire rx_update_edge_select,
  input wire [2:0] buildout_code,
  input wire [1:0] rx_sensitivity,
  input wire jitter_atten_side,
  input wire jitter_atten_disable,
  input wire [7:0] jitter_depth_bits,
  input wire line_reset_active
);
  reg [7:0] last_two;
  reg [7:0] last_four;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_two; wr_en && addr == 5'h01; endsequence
  sequence wr_four; wr_en && addr == 5'h03; endsequence
  sequence pulse_body; line_reset_active [*4] ##1 !line_reset_active; endsequence
  // last written bytes, so a later write cannot hide a stale copy
  always @(posedge clk) begin
    if (wr_en && addr == 5'h01) last_two <= wr_data;
    if (wr_en && addr == 5'h03) last_four <= wr_data;
  end
  chk_subst_bits: assert property (wr_two |-> ##[1:2]
    {rx_zero_subst_disable, tx_zero_subst_disable} == last_two[3:2]) else $error("subst bits");
  chk_rx_edge: assert property (wr_two |-> ##[1:2]
    rx_update_edge_select == last_two[0]) else $error("rx edge select");
  chk_buildout_code: assert property (wr_four |-> ##[1:2]
    buildout_code == last_four[7:5]) else $error("buildout code");
  chk_gain_sens: assert property (wr_four |-> ##[1:2]
    rx_sensitivity == {e1_t1_select, last_four[4]}) else $error("sensitivity");
  chk_jitter_place: assert property (wr_four |-> ##[1:2]
    {jitter_atten_side, jitter_atten_disable} == {last_four[3], last_four[1]})
    else $error("jitter placement");
  chk_depth_follow: assert property (wr_four |-> ##[1:2]
    jitter_depth_bits == (last_four[2] ? 8'h20 : 8'h80)) else $error("depth");
  chk_power_down: assert property (wr_four and wr_data[0] |-> ##[1:3] !line_out_oe)
    else $error("power down");
  chk_line_pulse: assert property ($rose(line_reset_active) |-> pulse_body)
    else $error("line reset length");
  chk_hw_defaults: assert property (!hardware_reset_n [*4] |=>
    buildout_code == 3'h0 && jitter_depth_bits == 8'h80) else $error("hw reset");
endmodule

/* File: line_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// host processor on the register port
module line_host_model (
  // clock
  input wire clk,
  // register port
  output reg wr_en,
  output reg rd_en,
  output reg [4:0] addr,
  output reg [7:0] wr_data,
  input wire [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 5'h00;
    wr_data = 8'h00;
  end
  // released lines show the inverse, never the stale value
  task wr(input [4:0] a, input [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask
  task rd(input [4:0] a, output [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 d = rd_data;
  endtask
  // program every control first, then toggle line reset
  task bring_up(input [7:0] c2, input [7:0] c3, input [7:0] c4);
    wr(5'h01, c2);
    wr(5'h02, c3 & 8'hFB);
    wr(5'h03, c4);
    wr(5'h02, c3 | 8'h04);
  endtask
endmodule

/* File: line_interface_control_regs_tb_top.sv */
`timescale 1ns/1ns
// ==========================================================
// bench top
module line_interface_control_regs_tb_top;
  reg clk, rst, hardware_reset_n, hardware_mode, e1_t1_select, tx_clock_in_run, rxd_run;
  reg tx_clock_in, jitter_atten_clock, tx_positive_data, rx_line_data;
  reg [7:0] div;
  wire wr_en, rd_en, line_out_a, line_out_b, line_out_oe, line_open_drain, status_pin;
  wire rx_carrier_loss, rx_zero_subst_disable, tx_zero_subst_disable, rx_update_edge_select;
  wire jitter_atten_side, jitter_atten_disable, line_reset_active;
  wire [4:0] addr;
  wire [7:0] wr_data, rd_data, jitter_depth_bits;
  wire [2:0] buildout_code;
  wire [1:0] rx_sensitivity;
  integer failures, n_checks, k, m;
  reg [7:0] v;
  line_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data));
  line_interface_control_regs dut (.clk(clk), .rst(rst), .hardware_reset_n(hardware_reset_n),
    .hardware_mode(hardware_mode), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .e1_t1_select(e1_t1_select),
    .tx_code_def_one(8'hA5), .tx_code_def_two(8'h3C), .tx_clock_in(tx_clock_in),
    .jitter_atten_clock(jitter_atten_clock), .tx_positive_data(tx_positive_data),
    .tx_negative_data(1'b0), .rx_line_data(rx_line_data), .rx_all_ones(1'b0),
    .line_out_a(line_out_a), .line_out_b(line_out_b), .line_out_oe(line_out_oe),
    .line_open_drain(line_open_drain), .status_pin(status_pin),
    .rx_carrier_loss(rx_carrier_loss), .rx_zero_subst_disable(rx_zero_subst_disable),
    .tx_zero_subst_disable(tx_zero_subst_disable),
    .rx_update_edge_select(rx_update_edge_select), .buildout_code(buildout_code),
    .rx_sensitivity(rx_sensitivity), .jitter_atten_side(jitter_atten_side),
    .jitter_atten_disable(jitter_atten_disable), .jitter_depth_bits(jitter_depth_bits),
    .line_reset_active(line_reset_active));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // slow line clocks; tx_clock_in_run low freezes the tx clock
  always @(posedge clk) begin
    div <= div + 8'h01;
    if (tx_clock_in_run) tx_clock_in <= div[2];
    jitter_atten_clock <= div[2];
    tx_positive_data <= div[4];
    rx_line_data <= div[3] & rxd_run;
  end
  task check(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      $display("unexpected %0s expected %h seen %h", name, exp, got);
      failures = failures + 1;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task count_pulse(output integer c);
    c = 0;
    repeat (12) begin
      @(posedge clk);
      #1 if (line_reset_active === 1'b1) c = c + 1;
    end
  endtask
  task t_reset;
    for (k = 1; k < 4; k = k + 1) begin
      host.rd(k[4:0], v);
      check("reg", 8'h00, v);
    end
    check("depth", 8'h80, jitter_depth_bits);
  endtask
  task t_all_ones;
    k = 0;
    m = 0;
    repeat (200) begin
      @(posedge clk);
      #1 if (line_out_a === 1'b1) k = 1;
      if (line_out_b === 1'b1) m = 1;
    end
    check("marks", 8'h03, {6'h00, k[0], m[0]});
  endtask
  task t_fields;
    e1_t1_select <= 1'b1;
    host.wr(5'h01, 8'h8D);
    host.wr(5'h03, 8'hFF);
    host.rd(5'h01, v);
    check("ctrl_two", 8'h8D, v);
    check("subst", 8'h07, {5'h00, rx_zero_subst_disable, tx_zero_subst_disable,
      rx_update_edge_select});
    check("four", 8'hFA, {buildout_code, 1'b1, jitter_atten_side, 1'b0,
      jitter_atten_disable, line_out_oe});
    check("depth", 8'h20, jitter_depth_bits);
    check("sens", 8'h03, {6'h00, rx_sensitivity});
    host.rd(5'h05, v);
    check("unmapped", 8'h00, v);
    host.wr(5'h05, 8'hFF);
    host.rd(5'h01, v);
    check("ctrl_two", 8'h8D, v);
    e1_t1_select <= 1'b0;
  endtask
  task t_driver;
    host.wr(5'h01, 8'h10);
    host.wr(5'h03, 8'h20);
    repeat (3) @(posedge clk);
    #1 check("open_drain", 8'h01, {7'h00, line_open_drain});
    host.wr(5'h03, 8'h00);
    repeat (3) @(posedge clk);
    #1 check("open_drain", 8'h00, {7'h00, line_open_drain});
    check("square", 8'h01, {7'h00, line_out_a ^ line_out_b});
    v = {7'h00, line_out_a};
    repeat (8) @(posedge clk);
    #1 check("square_flip", {7'h00, ~v[0]}, {7'h00, line_out_a});
  endtask
  task t_stall;
    host.wr(5'h01, 8'h80);
    tx_clock_in_run <= 1'b0;
    k = 0;
    while (status_pin !== 1'b1) begin
      @(posedge clk);
      #1 k = k + 1;
      if (k > 80) begin
        check("stall", 8'h01, 8'h00);
        report_and_stop;
      end
    end
    check("stall_late", 8'h01, {7'h00, k > 48});
    hardware_mode <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check("hw_mode", 8'h00, {7'h00, status_pin});
    hardware_mode <= 1'b0;
    tx_clock_in_run <= 1'b1;
  endtask
  task t_line_reset;
    host.bring_up(8'h00, 8'h80, 8'h00);
    count_pulse(k);
    check("pulse", 8'h04, k[7:0]);
    host.wr(5'h02, 8'h84);
    count_pulse(k);
    check("rewrite", 8'h00, k[7:0]);
    host.wr(5'h02, 8'h80);
    host.wr(5'h02, 8'h84);
    count_pulse(k);
    check("pulse", 8'h04, k[7:0]);
  endtask
  task t_carrier_loss;
    rxd_run <= 1'b0;
    repeat (2000) @(posedge clk);
    #1 check("loss_early", 8'h00, {7'h00, rx_carrier_loss});
    k = 0;
    while (status_pin !== 1'b1) begin
      @(posedge clk);
      #1 k = k + 1;
      if (k > 100) begin
        check("loss_late", 8'h01, 8'h00);
        report_and_stop;
      end
    end
    check("loss", 8'h01, {7'h00, rx_carrier_loss});
    host.wr(5'h02, 8'hC4);
    repeat (20) @(posedge clk);
    m = 0;
    repeat (64) begin
      @(posedge clk);
      #1 if ((line_out_a | line_out_b) !== 1'b1) m = m + 1;
    end
    check("auto_ones", 8'h00, m[7:0]);
    rxd_run <= 1'b1;
    repeat (30) @(posedge clk);
    #1 check("loss_clear", 8'h00, {7'h00, status_pin});
  endtask
  task t_hw_reset;
    host.wr(5'h03, 8'hE4);
    hardware_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    hardware_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (k = 1; k < 4; k = k + 1) begin
      host.rd(k[4:0], v);
      check("hw_reset", 8'h00, v);
    end
  endtask
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    hardware_reset_n = 1'b1;
    hardware_mode = 1'b0;
    e1_t1_select = 1'b0;
    tx_clock_in_run = 1'b1;
    rxd_run = 1'b1;
    div = 8'h00;
    tx_clock_in = 1'b0;
    jitter_atten_clock = 1'b0;
    tx_positive_data = 1'b0;
    rx_line_data = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_all_ones;
    t_fields;
    t_driver;
    t_stall;
    t_line_reset;
    t_carrier_loss;
    t_hw_reset;
    report_and_stop;
  end
endmodule
bind line_interface_control_regs line_ctrl_checks chk (.clk(clk), .rst(rst),
  .hardware_reset_n(hardware_reset_n), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
  .e1_t1_select(e1_t1_select), .line_out_oe(line_out_oe),
  .rx_zero_subst_disable(rx_zero_subst_disable), .tx_zero_subst_disable(tx_zero_subst_disable),
  .rx_update_edge_select(rx_update_edge_select), .buildout_code(buildout_code),
  .rx_sensitivity(rx_sensitivity), .jitter_atten_side(jitter_atten_side),
  .jitter_atten_disable(jitter_atten_disable), .jitter_depth_bits(jitter_depth_bits),
  .line_reset_active(line_reset_active));
